// ===== bragen_map.svh
// Purpose: offsets, field positions and reset values of the bit-reversed AGU
// Assumes: included by the package and by the top module
// Notes: definitions only
`ifndef BRAGEN_MAP_SVH
`define BRAGEN_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BRAGEN_ADDR_W 8
`define BRAGEN_OFS_MODCTL 8'h00
`define BRAGEN_OFS_BRCTL 8'h04
`define BRAGEN_OFS_STATUS 8'h08

// ----------------------------------------
// fields
// ----------------------------------------
`define BRAGEN_DATA_W 16
`define BRAGEN_PTR_W 16
`define BRAGEN_SEL_HI 3
`define BRAGEN_SEL_LO 0
`define BRAGEN_SEL_STACK 4'hF
`define BRAGEN_XR_MOD_BIT 13
`define BRAGEN_Y_MOD_BIT 14
`define BRAGEN_XW_MOD_BIT 15
`define BRAGEN_BITREV_ENABLE_BIT 15
`define BRAGEN_PIV_HI 14
`define BRAGEN_PIV_LO 0
`define BRAGEN_STAT_ACT_BIT 0
`define BRAGEN_STAT_EA_LO 16

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define BRAGEN_MODCTL_RST 16'h000F
`define BRAGEN_BRCTL_RST 16'h0000
`define BRAGEN_WORD_INC 16'h0002
`define BRAGEN_BYTE_INC 16'h0001
`define BRAGEN_RESP_OKAY 2'h0
`define BRAGEN_RESP_SLVERR 2'h2

`endif

// ===== bragen_pkg.sv
// Purpose: types shared by the bit-reversed address generator
// Assumes: bragen_map.svh defines widths
// Notes: state of the top is one packed struct
`include "bragen_map.svh"

package bragen_pkg;

    // ----------------------------------------
    // addressing modes of a write access
    // ----------------------------------------
    typedef enum logic [2:0] {
        BRAGEN_AM_DIRECT = 3'h0,
        BRAGEN_AM_POST_DEC = 3'h1,
        BRAGEN_AM_POST_INC = 3'h3,
        BRAGEN_AM_PRE_DEC = 3'h2,
        BRAGEN_AM_PRE_INC = 3'h6,
        BRAGEN_AM_OFFSET = 3'h7
    } bragen_am_e;

    typedef logic [`BRAGEN_PTR_W-1:0] bragen_ptr_t;
    typedef logic [`BRAGEN_DATA_W-1:0] bragen_reg_t;

    typedef struct packed {
        bragen_reg_t modctl;
        bragen_reg_t brctl;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [`BRAGEN_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ack;
        bragen_ptr_t ea;
        logic wb_en;
        bragen_ptr_t wb_val;
        logic br_act;
        logic xw_mod_en;
        logic y_mod_en;
        logic xr_mod_en;
        bragen_ptr_t last_ea;
        logic last_act;
    } bragen_state_s;

endpackage : bragen_pkg

// ===== bragen_revc_add.sv
// Purpose: adder whose carries run from the msb toward the lsb
// Assumes: purely combinational, same clock as its user
// Notes: done by mirroring both operands, adding, mirroring back
`timescale 1ns/1ps

module bragen_revc_add #(
    parameter int W = 16
) (
    input wire logic [W-1:0] op_a,
    input wire logic [W-1:0] op_b,
    output logic [W-1:0] sum
);

    logic [W-1:0] a_rev;
    logic [W-1:0] b_rev;
    logic [W-1:0] s_rev;

    generate
        if (W < 2) begin : g_chk
            $error("bragen_revc_add needs W of at least 2");
        end
        for (genvar i = 0; i < W; i++) begin : g_mirror
            assign a_rev[i] = op_a[W-1-i];
            assign b_rev[i] = op_b[W-1-i];
            assign sum[i] = s_rev[W-1-i];
        end
    endgenerate

    // carry out of the mirrored msb is dropped: the address wraps in the buffer
    assign s_rev = a_rev + b_rev;

endmodule : bragen_revc_add

// ===== bragen_top.sv
// Purpose: X write address generator with bit-reversed addressing
// Assumes: AXI4-Lite master for the control registers; request port driven by core logic
// Notes: one request per cycle, results one cycle later
//
// Operation
// - Bit reversal is possible only when the pointer select field is not 15 (never the stack).
// - Bit reversal also needs the enable bit at position 15 of the bit-reverse control register.
// - Bit reversal also needs register indirect with pre- or post-increment addressing.
// - A 15-bit pivot modifier is held and doubled into byte units before use.
// - Every bit-reversed address is word aligned, its lsb forced to zero.
// - Only word writes in pre/post-increment mode reverse; bytes and other modes stay normal.
// - When active the pointer is added to the pivot and the normal increment is ignored.
// - Bit reversal wins over modulo and turns modulo off in the X write and Y generators.
// - Modulo correction stays on in the X read generator while bit reversal is active.
// - Bit reversal exists only in the X generator and only for data writes.
// - The modifier is taken in normal bit order with its carries run toward the lsb; pointer and result stay in normal order.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "bragen_map.svh"

module bragen_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [`BRAGEN_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`BRAGEN_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // x data-write request from the execution logic
    input wire logic agu_req,
    input wire logic [3:0] agu_ptr_sel,
    input wire bragen_pkg::bragen_am_e agu_mode,
    input wire logic agu_byte,
    input wire bragen_pkg::bragen_ptr_t agu_ptr,
    input wire bragen_pkg::bragen_ptr_t agu_offset,
    output logic agu_ack,
    output bragen_pkg::bragen_ptr_t agu_ea,
    output logic agu_wb_en,
    output bragen_pkg::bragen_ptr_t agu_wb_val,
    output logic agu_br_active,
    output logic xw_mod_en,
    output logic y_mod_en,
    output logic xr_mod_en
);
    import bragen_pkg::*;

    bragen_state_s st_r;
    bragen_state_s st_nxt;
    bragen_ptr_t rev_sum;
    bragen_ptr_t ptr_even;
    bragen_ptr_t piv_bytes;
    logic [`BRAGEN_PTR_W-2:0] rev_word;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic bragen_reg_t merge_lanes(input bragen_reg_t cur,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        bragen_reg_t res;
        res = cur;
        for (int b = 0; b < 2; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_lanes

    function automatic logic is_mapped(input logic [`BRAGEN_ADDR_W-1:0] a);
        return (a == `BRAGEN_OFS_MODCTL) || (a == `BRAGEN_OFS_BRCTL) ||
               (a == `BRAGEN_OFS_STATUS);
    endfunction : is_mapped

    // ----------------------------------------
    // reversed-carry adder
    // ----------------------------------------
    // pivot doubled into bytes; lsb of the pointer ignored for word data
    assign piv_bytes = {st_r.brctl[`BRAGEN_PIV_HI:`BRAGEN_PIV_LO], 1'b0};
    assign ptr_even = {agu_ptr[`BRAGEN_PTR_W-1:1], 1'b0};

    // added in word units: a carry that would reach the byte lsb is lost,
    // so the result stays even and wraps inside an aligned buffer
    bragen_revc_add #(
        .W(`BRAGEN_PTR_W-1)
    ) u_revc (
        .op_a(ptr_even[`BRAGEN_PTR_W-1:1]),
        .op_b(piv_bytes[`BRAGEN_PTR_W-1:1]),
        .sum(rev_word)
    );
    assign rev_sum = {rev_word, 1'b0};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic br_elig;
        logic br_go;
        logic mod_xw;
        logic mod_y;
        bragen_ptr_t inc;
        bragen_ptr_t nrm_next;
        st_nxt = st_r;
        br_elig = 1'b0;
        br_go = 1'b0;
        mod_xw = 1'b0;
        mod_y = 1'b0;
        inc = agu_byte ? `BRAGEN_BYTE_INC : `BRAGEN_WORD_INC;
        nrm_next = agu_ptr;

        // --- register bus, write side ---
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awready = 1'b0;
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wready = 1'b0;
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = is_mapped(st_r.awaddr) ? `BRAGEN_RESP_OKAY : `BRAGEN_RESP_SLVERR;
            case (st_r.awaddr)
                `BRAGEN_OFS_MODCTL: begin
                    st_nxt.modctl = merge_lanes(st_r.modctl, st_r.wdata, st_r.wstrb);
                end
                // new value steers requests from the next cycle on
                `BRAGEN_OFS_BRCTL: begin
                    st_nxt.brctl = merge_lanes(st_r.brctl, st_r.wdata, st_r.wstrb);
                end
                default: begin
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready = 1'b1;
        end

        // --- register bus, read side ---
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = is_mapped(s_axi_araddr) ? `BRAGEN_RESP_OKAY : `BRAGEN_RESP_SLVERR;
            case (s_axi_araddr)
                `BRAGEN_OFS_MODCTL: st_nxt.rdata = {16'h0000, st_r.modctl};
                `BRAGEN_OFS_BRCTL: st_nxt.rdata = {16'h0000, st_r.brctl};
                `BRAGEN_OFS_STATUS: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rdata[`BRAGEN_STAT_EA_LO +: `BRAGEN_PTR_W] = st_r.last_ea;
                    st_nxt.rdata[`BRAGEN_STAT_ACT_BIT] = st_r.last_act;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // --- bit-reverse enabling ---
        // this port carries x data writes only, so reversal never reaches reads
        br_elig = (st_r.modctl[`BRAGEN_SEL_HI:`BRAGEN_SEL_LO] != `BRAGEN_SEL_STACK) &&
                  st_r.brctl[`BRAGEN_BITREV_ENABLE_BIT];
        br_go = br_elig && !agu_byte &&
                (agu_ptr_sel == st_r.modctl[`BRAGEN_SEL_HI:`BRAGEN_SEL_LO]) &&
                ((agu_mode == BRAGEN_AM_PRE_INC) || (agu_mode == BRAGEN_AM_POST_INC));

        // --- modulo gating ---
        // modulo gated whenever the request inputs qualify for reversal, even while agu_req is low
        mod_xw = st_r.modctl[`BRAGEN_XW_MOD_BIT] && !br_go;
        mod_y = st_r.modctl[`BRAGEN_Y_MOD_BIT] && !br_go;
        st_nxt.xw_mod_en = mod_xw;
        st_nxt.y_mod_en = mod_y;
        st_nxt.xr_mod_en = st_r.modctl[`BRAGEN_XR_MOD_BIT];

        // --- effective address ---
        st_nxt.ack = agu_req;
        st_nxt.br_act = agu_req && br_go;
        if (agu_req) begin
            st_nxt.wb_en = 1'b0;
            st_nxt.wb_val = agu_ptr;
            case (agu_mode)
                BRAGEN_AM_POST_INC: begin
                    nrm_next = agu_ptr + inc;
                    st_nxt.ea = agu_ptr;
                    st_nxt.wb_en = 1'b1;
                end
                BRAGEN_AM_PRE_INC: begin
                    nrm_next = agu_ptr + inc;
                    st_nxt.ea = nrm_next;
                    st_nxt.wb_en = 1'b1;
                end
                BRAGEN_AM_POST_DEC: begin
                    nrm_next = agu_ptr - inc;
                    st_nxt.ea = agu_ptr;
                    st_nxt.wb_en = 1'b1;
                end
                BRAGEN_AM_PRE_DEC: begin
                    nrm_next = agu_ptr - inc;
                    st_nxt.ea = nrm_next;
                    st_nxt.wb_en = 1'b1;
                end
                BRAGEN_AM_OFFSET: st_nxt.ea = agu_ptr + agu_offset;
                default: st_nxt.ea = agu_ptr;
            endcase
            st_nxt.wb_val = nrm_next;
            if (br_go) begin
                // increment is dropped; pivot is added with reversed carries
                st_nxt.wb_val = rev_sum;
                st_nxt.ea = (agu_mode == BRAGEN_AM_PRE_INC) ? rev_sum : ptr_even;
            end
            st_nxt.last_ea = st_nxt.ea;
            st_nxt.last_act = br_go;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.modctl <= `BRAGEN_MODCTL_RST;
            st_r.brctl <= `BRAGEN_BRCTL_RST;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign agu_ack = st_r.ack;
    assign agu_ea = st_r.ea;
    assign agu_wb_en = st_r.wb_en;
    assign agu_wb_val = st_r.wb_val;
    assign agu_br_active = st_r.br_act;
    assign xw_mod_en = st_r.xw_mod_en;
    assign y_mod_en = st_r.y_mod_en;
    assign xr_mod_en = st_r.xr_mod_en;

endmodule : bragen_top

// ===== bragen_checker.sv
// Purpose: concurrent checks on the bit-reversed address generator
// Assumes: sees only the top-level ports
// Notes: bound to the top at the foot of this file
`timescale 1ns/1ps

module bragen_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic agu_req,
    input wire logic [3:0] agu_ptr_sel,
    input wire bragen_pkg::bragen_am_e agu_mode,
    input wire logic agu_byte,
    input wire bragen_pkg::bragen_ptr_t agu_ptr,
    input wire logic agu_ack,
    input wire bragen_pkg::bragen_ptr_t agu_ea,
    input wire bragen_pkg::bragen_ptr_t agu_wb_val,
    input wire logic agu_br_active,
    input wire logic xw_mod_en,
    input wire logic y_mod_en,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    import bragen_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // request and answer
    // ----------------------------------------
    sequence s_post_br;
        agu_req && agu_mode == BRAGEN_AM_POST_INC ##1 agu_br_active;
    endsequence
    chk_ack_follow: assert property (agu_req |=> agu_ack)
        else $error("ack missing after request");
    chk_ack_lone: assert property (!agu_req |=> !agu_ack)
        else $error("ack without request");
    chk_stack_off: assert property (
        agu_req && agu_ptr_sel == 4'hF |=> !agu_br_active)
        else $error("stack pointer reversed");
    chk_mode_only: assert property (
        agu_req && agu_mode != BRAGEN_AM_PRE_INC && agu_mode != BRAGEN_AM_POST_INC
        |=> !agu_br_active)
        else $error("reversal in wrong mode");
    chk_byte_plain: assert property (agu_req && agu_byte |=> !agu_br_active)
        else $error("byte access reversed");
    chk_word_lsb: assert property (agu_br_active |-> !agu_ea[0] && !agu_wb_val[0])
        else $error("reversed address odd");
    chk_mod_gate: assert property (agu_br_active |-> !xw_mod_en && !y_mod_en)
        else $error("modulo left on during reversal");
    chk_post_ea: assert property (s_post_br |-> agu_ea == ($past(agu_ptr) & 16'hFFFE))
        else $error("post increment address not the pointer");
    chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after taken");
endmodule : bragen_checker

bind bragen_top bragen_checker chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .agu_req(agu_req),
    .agu_ptr_sel(agu_ptr_sel), .agu_mode(agu_mode), .agu_byte(agu_byte),
    .agu_ptr(agu_ptr), .agu_ack(agu_ack), .agu_ea(agu_ea), .agu_wb_val(agu_wb_val),
    .agu_br_active(agu_br_active), .xw_mod_en(xw_mod_en), .y_mod_en(y_mod_en),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);

// ===== bragen_cpu_model.sv
// Purpose: execution-logic side that issues x data writes
// Assumes: holds the pointer file and writes back what the block returns
// Notes: one request at a time; never reads right after a control write
`timescale 1ns/1ps

module bragen_cpu_model (
    input wire logic core_clk,
    input wire logic agu_ack,
    input wire logic agu_wb_en,
    input wire bragen_pkg::bragen_ptr_t agu_wb_val,
    output logic agu_req,
    output logic [3:0] agu_ptr_sel,
    output bragen_pkg::bragen_am_e agu_mode,
    output logic agu_byte,
    output bragen_pkg::bragen_ptr_t agu_ptr,
    output bragen_pkg::bragen_ptr_t agu_offset
);
    import bragen_pkg::*;
    bragen_ptr_t wreg [16];
    initial begin
        agu_req = 1'b0;
        agu_ptr_sel = 4'h0;
        agu_mode = BRAGEN_AM_DIRECT;
        agu_byte = 1'b0;
        agu_ptr = 16'h0000;
        agu_offset = 16'h0010;
    end
    task automatic issue(input logic [3:0] s, input bragen_am_e m, input logic b);
        @(posedge core_clk);
        agu_req <= 1'b1;
        agu_ptr_sel <= s;
        agu_mode <= m;
        agu_byte <= b;
        agu_ptr <= wreg[s];
        @(posedge core_clk);
        agu_req <= 1'b0;
        // stale pointer hidden once taken
        agu_ptr <= ~wreg[s];
        #1;
        if (agu_ack && agu_wb_en) begin
            wreg[s] = agu_wb_val;
        end
    endtask : issue
endmodule : bragen_cpu_model

// ===== testbench.sv
// Purpose: self-checking bench of the bit-reversed address generator
// Assumes: registers over axi4-lite, requests through the cpu model
// Notes: every bus and request task starts at a clock edge
`timescale 1ns/1ps

module testbench;
    import bragen_pkg::*;
    logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, agu_req, agu_byte, agu_ack, agu_wb_en;
    logic agu_br_active, xw_mod_en, y_mod_en, xr_mod_en;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] agu_ptr_sel;
    bragen_am_e agu_mode;
    bragen_ptr_t agu_ptr, agu_offset, agu_ea, agu_wb_val;
    int miscompares = 0;
    int num_checks = 0;
    bragen_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .agu_req(agu_req),
        .agu_ptr_sel(agu_ptr_sel), .agu_mode(agu_mode), .agu_byte(agu_byte),
        .agu_ptr(agu_ptr), .agu_offset(agu_offset), .agu_ack(agu_ack), .agu_ea(agu_ea),
        .agu_wb_en(agu_wb_en), .agu_wb_val(agu_wb_val), .agu_br_active(agu_br_active),
        .xw_mod_en(xw_mod_en), .y_mod_en(y_mod_en), .xr_mod_en(xr_mod_en));
    bragen_cpu_model part_u (.core_clk(core_clk), .agu_ack(agu_ack), .agu_wb_en(agu_wb_en),
        .agu_wb_val(agu_wb_val), .agu_req(agu_req), .agu_ptr_sel(agu_ptr_sel),
        .agu_mode(agu_mode), .agu_byte(agu_byte), .agu_ptr(agu_ptr), .agu_offset(agu_offset));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no cycle limit here: only the watchdog ends a wait
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, rsp}, {30'h0, bresp});
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, rsp}, {30'h0, rresp});
    endtask : axi_rd
    task automatic do_req(input logic [3:0] s, input bragen_am_e m, input logic b,
                          input bragen_ptr_t p, input bragen_ptr_t ea, input logic br);
        logic wb;
        wb = (m != BRAGEN_AM_DIRECT) && (m != BRAGEN_AM_OFFSET);
        part_u.wreg[s] = p;
        part_u.issue(s, m, b);
        chk("agu_ack", 32'h1, {31'h0, agu_ack});
        chk("agu_wb_en", {31'h0, wb}, {31'h0, agu_wb_en});
        chk("agu_ea", {16'h0, ea}, {16'h0, agu_ea});
        chk("agu_br_active", {31'h0, br}, {31'h0, agu_br_active});
    endtask : do_req
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        axi_rd(8'h00, 32'h0000_000F, 2'h0);
        axi_rd(8'h04, 32'h0000_0000, 2'h0);
        axi_rd(8'h0C, 32'h0000_0000, 2'h2);
        axi_wr(8'h0C, 32'h0000_1234, 2'h2);
    endtask : t_regs
    task automatic t_fft;
        bragen_ptr_t seq [8] = '{16'h0100, 16'h0108, 16'h0104, 16'h010C,
                                 16'h0102, 16'h010A, 16'h0106, 16'h010E};
        axi_wr(8'h00, 32'h0000_E003, 2'h0);
        axi_wr(8'h04, 32'h0000_8004, 2'h0);
        axi_rd(8'h04, 32'h0000_8004, 2'h0);
        part_u.wreg[3] = 16'h0100;
        for (int i = 0; i < 8; i++) begin
            do_req(4'h3, BRAGEN_AM_POST_INC, 1'b0, part_u.wreg[3], seq[i], 1'b1);
        end
        // the walk wraps back to the buffer start
        chk("wrapped pointer", 32'h0100, {16'h0, part_u.wreg[3]});
        chk("xw_mod_en", 32'h0, {31'h0, xw_mod_en});
        chk("xr_mod_en", 32'h1, {31'h0, xr_mod_en});
        do_req(4'h3, BRAGEN_AM_PRE_INC, 1'b0, 16'h0100, 16'h0108, 1'b1);
        do_req(4'h3, BRAGEN_AM_POST_INC, 1'b0, 16'h0101, 16'h0100, 1'b1);
        axi_rd(8'h08, 32'h0100_0001, 2'h0);
    endtask : t_fft
    task automatic t_plain;
        bragen_am_e md [4] = '{BRAGEN_AM_POST_DEC, BRAGEN_AM_PRE_DEC, BRAGEN_AM_DIRECT,
                               BRAGEN_AM_OFFSET};
        bragen_ptr_t ex [4] = '{16'h0200, 16'h01FE, 16'h0200, 16'h0210};
        for (int i = 0; i < 4; i++) begin
            do_req(4'h3, md[i], 1'b0, 16'h0200, ex[i], 1'b0);
        end
        do_req(4'h3, BRAGEN_AM_POST_INC, 1'b1, 16'h0200, 16'h0200, 1'b0);
        do_req(4'h5, BRAGEN_AM_POST_INC, 1'b0, 16'h0200, 16'h0200, 1'b0);
        axi_wr(8'h04, 32'h0000_0004, 2'h0);
        do_req(4'h3, BRAGEN_AM_POST_INC, 1'b0, 16'h0200, 16'h0200, 1'b0);
        // select 15 keeps reversal off while modulo is on
        axi_wr(8'h00, 32'h0000_E00F, 2'h0);
        axi_wr(8'h04, 32'h0000_8004, 2'h0);
        do_req(4'hF, BRAGEN_AM_POST_INC, 1'b0, 16'h0200, 16'h0200, 1'b0);
        chk("xw_mod_en", 32'h1, {31'h0, xw_mod_en});
    endtask : t_plain
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
    initial begin
        sys_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_fft();
        t_plain();
        end_sim();
    end
endmodule : testbench
